// ==== hdl/nvram_rd_map.vh ====
`ifndef NVRAM_RD_MAP_VH
`define NVRAM_RD_MAP_VH
// ----------------------------------------
// Slave address fields
// ----------------------------------------
`define TYPE_CODE 4'h5
`define TYPE_MSB 7
`define TYPE_LSB 4
`define PAGE_MSB 3
`define PAGE_LSB 1
`define RW_BIT 0
// ----------------------------------------
// Array geometry and reset values
// ----------------------------------------
`define ADDR_W 11
`define LOW_W 8
`define PAGE_W 3
`define DATA_W 8
`define ADDR_RST 11'h000
`define ADDR_TOP 11'h7ff
`define BITS_PER_BYTE 4'h8
`endif

// ==== hdl/nvram_array.v ====
`include "nvram_rd_map.vh"
module nvram_array #(
    parameter AW = 11,
    parameter DW = 8
) (
    // Clock
    input wire clk_sys,
    // Write port
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [DW-1:0] wr_data,
    // Read port
    input wire [AW-1:0] rd_addr,
    output wire [DW-1:0] rd_data
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // Synchronous write, asynchronous read
    always @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end
    assign rd_data = mem[rd_addr];
endmodule

// ==== hdl/nvram_read_path.v ====
`include "nvram_rd_map.vh"
module nvram_read_path #(
    parameter [3:0] TYPE_CODE = `TYPE_CODE // Arbitrary neutral value
) (
    // Clock and reset
    input wire clk_sys,
    input wire reset_n,
    // Two-wire bus
    input wire scl_in,
    input wire sda_in,
    output reg sda_out_q,
    output reg sda_oe_q,
    // Back-door array load
    input wire load_en,
    input wire [`ADDR_W-1:0] load_addr,
    input wire [`DATA_W-1:0] load_data,
    // Status
    output reg busy_q
);
    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam [2:0] S_IDLE = 3'd0;
    localparam [2:0] S_SADDR = 3'd1;
    localparam [2:0] S_SACK = 3'd2;
    localparam [2:0] S_WADDR = 3'd3;
    localparam [2:0] S_WACK = 3'd4;
    localparam [2:0] S_RDATA = 3'd5;
    localparam [2:0] S_MACK = 3'd6;
    localparam [2:0] S_WDATA = 3'd7;

    reg [1:0] scl_sync_q;
    reg [1:0] sda_sync_q;
    reg scl_q;
    reg sda_q;
    reg [2:0] state_q;
    reg [3:0] bit_cnt_q;
    reg [7:0] shift_q;
    reg rw_q;
    reg [`ADDR_W-1:0] addr_q;
    wire [`DATA_W-1:0] rd_data;
    wire scl_rise;
    wire scl_fall;
    wire start_cond;
    wire stop_cond;
    wire type_match;

    // Two-flop synchronisers, then one delay stage for edges
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            scl_sync_q <= 2'b11;
            sda_sync_q <= 2'b11;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[0], scl_in};
            sda_sync_q <= {sda_sync_q[0], sda_in};
            scl_q <= scl_sync_q[1];
            sda_q <= sda_sync_q[1];
        end
    end

    // Bus events
    assign scl_rise = scl_sync_q[1] & ~scl_q;
    assign scl_fall = ~scl_sync_q[1] & scl_q;
    assign start_cond = scl_sync_q[1] & scl_q & sda_q & ~sda_sync_q[1];
    assign stop_cond = scl_sync_q[1] & scl_q & ~sda_q & sda_sync_q[1];
    assign type_match = (shift_q[`TYPE_MSB:`TYPE_LSB] == TYPE_CODE);

    // ----------------------------------------
    // Memory array
    // ----------------------------------------
    nvram_array #(
        .AW(`ADDR_W),
        .DW(`DATA_W)
    ) u_array (
        .clk_sys(clk_sys),
        .wr_en(load_en),
        .wr_addr(load_addr),
        .wr_data(load_data),
        .rd_addr(addr_q),
        .rd_data(rd_data)
    );

    // ----------------------------------------
    // Protocol engine
    // ----------------------------------------
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= S_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            rw_q <= 1'b0;
            addr_q <= `ADDR_RST;
            sda_out_q <= 1'b1;
            sda_oe_q <= 1'b0;
            busy_q <= 1'b0;
        end else if (start_cond) begin
            // Any START aborts and awaits an address
            state_q <= S_SADDR;
            bit_cnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
            busy_q <= 1'b1;
        end else if (stop_cond) begin
            state_q <= S_IDLE;
            sda_oe_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    sda_oe_q <= 1'b0;
                end
                S_SADDR, S_WADDR, S_WDATA: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], sda_q};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == `BITS_PER_BYTE) begin
                        bit_cnt_q <= 4'h0;
                        if (state_q == S_SADDR) begin
                            if (type_match) begin
                                rw_q <= shift_q[`RW_BIT];
                                // Page bits replace the top of the latch
                                addr_q[`ADDR_W-1:`LOW_W] <= shift_q[`PAGE_MSB:`PAGE_LSB];
                                sda_out_q <= 1'b0;
                                sda_oe_q <= 1'b1;
                                state_q <= S_SACK;
                            end else begin
                                state_q <= S_IDLE;
                                busy_q <= 1'b0;
                            end
                        end else if (state_q == S_WADDR) begin
                            addr_q[`LOW_W-1:0] <= shift_q;
                            sda_out_q <= 1'b0;
                            sda_oe_q <= 1'b1;
                            state_q <= S_WACK;
                        end else begin
                            // Write data path not built here; stay released
                            state_q <= S_IDLE;
                            busy_q <= 1'b0;
                        end
                    end
                end
                S_SACK: begin
                    if (scl_fall) begin
                        if (rw_q) begin
                            // Current address from page plus latch
                            shift_q <= rd_data;
                            sda_out_q <= rd_data[7];
                            sda_oe_q <= 1'b1;
                            addr_q <= addr_q + 11'h001;
                            bit_cnt_q <= 4'h0;
                            state_q <= S_RDATA;
                        end else begin
                            sda_oe_q <= 1'b0;
                            state_q <= S_WADDR;
                        end
                    end
                end
                S_WACK: begin
                    if (scl_fall) begin
                        sda_oe_q <= 1'b0;
                        state_q <= S_WDATA; // START here aborts
                    end
                end
                S_RDATA: begin
                    if (scl_rise) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_q == `BITS_PER_BYTE) begin
                            sda_oe_q <= 1'b0; // Release for master ack
                            state_q <= S_MACK;
                        end else begin
                            shift_q <= {shift_q[6:0], 1'b0};
                            sda_out_q <= shift_q[6];
                        end
                    end
                end
                S_MACK: begin
                    if (scl_rise) begin
                        rw_q <= sda_q; // Sample ack level in ninth clock
                    end else if (scl_fall) begin
                        if (!rw_q) begin
                            // Ack: next sequential byte
                            shift_q <= rd_data;
                            sda_out_q <= rd_data[7];
                            sda_oe_q <= 1'b1;
                            addr_q <= addr_q + 11'h001;
                            bit_cnt_q <= 4'h0;
                            rw_q <= 1'b1;
                            state_q <= S_RDATA;
                        end else begin
                            // No-ack ends the read
                            state_q <= S_IDLE;
                            busy_q <= 1'b0;
                        end
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// ==== bench/nvram_read_path_checker.sv ====
module nvram_read_path_checker (
    // Clock and reset
    input logic clk_sys,
    input logic reset_n,
    // Bus and status
    input logic scl_in,
    input logic sda_in,
    input logic sda_out_q,
    input logic sda_oe_q,
    input logic busy_q
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Output timing against the bus clock
    property p_move_low; $changed(sda_out_q) && sda_oe_q |-> !scl_in; endproperty
    a_move_low: assert property (p_move_low) else $error("data moved with scl high");
    property p_drive_low; $rose(sda_oe_q) |-> !scl_in && busy_q; endproperty
    a_drive_low: assert property (p_drive_low) else $error("drive began badly");
    property p_free_low; $fell(sda_oe_q) |-> !scl_in; endproperty
    a_free_low: assert property (p_free_low) else $error("release with scl high");
    property p_hold_high;
        scl_in && $past(scl_in) && $past(scl_in, 2) && $past(scl_in, 3)
            |-> $stable(sda_oe_q) && $stable(sda_out_q);
    endproperty
    a_hold_high: assert property (p_hold_high) else $error("sda moved during scl high");
    // Framing conditions
    property p_stop_idle; scl_in && $rose(sda_in) |-> ##[1:6] !busy_q; endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop did not end op");
    property p_start_busy; scl_in && $fell(sda_in) |-> ##[1:6] busy_q; endproperty
    a_start_busy: assert property (p_start_busy) else $error("start not taken");
    property p_start_quiet; scl_in && $fell(sda_in) |-> !sda_oe_q [*8]; endproperty
    a_start_quiet: assert property (p_start_quiet) else $error("drive after start");
    property p_idle_quiet; !busy_q |-> !sda_oe_q; endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("drive while idle");
    // Main scenarios
    c_stop: cover property (scl_in && $rose(sda_in));
    c_drive: cover property ($rose(sda_oe_q));
    c_end: cover property (busy_q ##1 !busy_q);
endmodule
bind nvram_read_path nvram_read_path_checker u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q),
    .busy_q(busy_q));

// ==== bench/nvram_bus_master.sv ====
module nvram_bus_master (
    // Bus pins
    output logic scl,
    output logic sda_m,
    input logic sda_w
);
    timeunit 1ns;
    timeprecision 100ps;
    // Bus idles released, pulled high
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // One bit of an 80 ns bus clock: drive while low, sample at high
    task automatic bitx(input logic b, output logic r);
        sda_m = b;
        #20 scl = 1'b1;
        #20 r = sda_w;
        #20 scl = 1'b0;
        #20;
    endtask
    // Start, also as a repeated start
    task automatic start();
        sda_m = 1'b1;
        #20 scl = 1'b1;
        #20 sda_m = 1'b0;
        #20 scl = 1'b0;
        #20;
    endtask
    // Stop, leaves the bus idle
    task automatic stop();
        sda_m = 1'b0;
        #20 scl = 1'b1;
        #20 sda_m = 1'b1;
        #20;
    endtask
    // Byte out, returns the ack level
    task automatic wbyte(input logic [7:0] v, output logic ack);
        for (int i = 7; i >= 0; i--) bitx(v[i], ack);
        bitx(1'b1, ack);
    endtask
    // Byte in; e: 0 ack, 1 no-ack, 2 no ninth clock
    task automatic rbyte(input logic [1:0] e, output logic [7:0] v);
        logic d;
        for (int i = 7; i >= 0; i--) bitx(1'b1, v[i]);
        if (e != 2'd2) bitx(e[0], d);
    endtask
endmodule

// ==== bench/test_serial_nvram_read_path.sv ====
`include "nvram_rd_map.vh"
module test_serial_nvram_read_path;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic load_en = 1'b0;
    logic [10:0] load_addr = 11'h000;
    logic [7:0] load_data = 8'h00;
    wire scl, sda_m, sda_w, sda_out_q, sda_oe_q, busy_q;
    int bad_count = 0;
    int checks_done = 0;
    always #5 clk_sys = ~clk_sys;
    // Open-drain wire with pull-up
    assign sda_w = sda_m & (sda_oe_q ? sda_out_q : 1'b1);
    nvram_read_path DUT (.clk_sys(clk_sys), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_w),
        .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q), .load_en(load_en),
        .load_addr(load_addr), .load_data(load_data), .busy_q(busy_q));
    nvram_bus_master bfm (.scl(scl), .sda_m(sda_m), .sda_w(sda_w));
    function automatic logic [7:0] pat(input logic [10:0] a);
        return a[7:0] ^ {a[10:8], 5'h0b};
    endfunction
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Selective address set: write address then word byte
    task automatic setaddr(input logic [10:0] a);
        logic k;
        bfm.start();
        bfm.wbyte({`TYPE_CODE, a[10:8], 1'b0}, k);
        cmp8({7'h0, k}, 8'h00);
        bfm.wbyte(a[7:0], k);
        cmp8({7'h0, k}, 8'h00);
    endtask
    // Read n bytes expected from a, ending with e
    task automatic rd(input logic [10:0] a, input int n, input logic [1:0] e);
        logic k;
        logic [7:0] v;
        bfm.start();
        bfm.wbyte({`TYPE_CODE, a[10:8], 1'b1}, k);
        cmp8({7'h0, k}, 8'h00);
        for (int i = 0; i < n; i++) begin
            bfm.rbyte(i == n - 1 ? e : 2'd0, v);
            cmp8(v, pat(a + 11'(i)));
        end
    endtask
    task automatic t_idle();
        repeat (8) @(negedge clk_sys);
        cmp8({6'h0, busy_q, sda_oe_q}, 8'h00);
    endtask
    task automatic t_bad();
        logic k;
        logic [7:0] v;
        bfm.start();
        bfm.wbyte({`TYPE_CODE ^ 4'h1, 3'h0, 1'b1}, k);
        cmp8({7'h0, k}, 8'h01);
        bfm.rbyte(2'd1, v);
        cmp8(v, 8'hff);
        bfm.stop();
    endtask
    initial begin
        repeat (16) @(negedge clk_sys);
        reset_n = 1'b1;
        for (int i = 0; i < 12; i++) begin
            @(negedge clk_sys);
            load_en = 1'b1;
            load_addr = i < 4 ? 11'h7fe + 11'(i) : 11'h3c0 + 11'(i - 4);
            load_data = pat(load_addr);
        end
        @(negedge clk_sys);
        load_en = 1'b0;
        rd(11'h000, 1, 2'd1);
        bfm.stop();
        setaddr(11'h3c0);
        rd(11'h3c0, 4, 2'd1);
        rd(11'h3c4, 1, 2'd1);
        rd(11'h3c5, 1, 2'd2);
        bfm.stop();
        t_idle();
        setaddr(11'h7fe);
        rd(11'h7fe, 3, 2'd2);
        setaddr(11'h000);
        rd(11'h000, 2, 2'd1);
        bfm.stop();
        t_bad();
        t_idle();
        report_and_stop();
    end
    // Watchdog well past the expected run length
    initial begin
        #200000;
        bad_count++;
        report_and_stop();
    end
endmodule
